// ---- include/mcu_timer_pkg.sv ----
// constants, types and field layout shared by the timer/counter unit
//
// What this block does
// - timer mode ticks every twelve core cycles
// - counter mode ticks on pin falling edge
// - edge detection takes two cycles, rate halved
// - each count is high byte plus low byte
// - mode 0 counts thirteen bits, low top frozen
// - mode 1 counts a full sixteen bits
// - mode 2 is eight-bit with auto reload
// - mode 3 splits timer 0, timer 1 holds
// - timer 1 still counts while timer 0 split
// - third timer select 01 counts prescaled clock
// - prescale select picks twelve or twenty-four cycles
// - third timer select 10 counts gate pin falls
// - gate pin sampled each edge, count follows
// - select 11 counts prescaled while gate high
// - reload mode 0 reloads on overflow
// - reload mode 1 reloads on trigger falling edge
// - reload trigger is low clock halved internally
// - four capture registers plus one reload register
// - mode field decodes 13, 16, 8-reload, split
// - reload field 0X off, 10 mode 0, 11 mode 1
// - overflow and external flags cleared on service
// - run bit clear stops timer 0 or 1; split high half is run by the second run bit
package mcu_timer_pkg;

   // ----------------------------------------------------------------
   // divider counts in core cycles
   // ----------------------------------------------------------------
   localparam int unsigned BASE_DIV = 12;   // core cycles per base tick
   localparam logic [3:0] BASE_DIV_LAST = 4'(BASE_DIV - 1);

   // ----------------------------------------------------------------
   // synchronised pin indices
   // ----------------------------------------------------------------
   localparam int unsigned PIN_COUNT = 6;
   localparam int unsigned PIN_FIRST = 0;    // first_count_input
   localparam int unsigned PIN_SECOND = 1;   // second_count_input
   localparam int unsigned PIN_THIRD = 2;    // third_count_gate_input
   localparam int unsigned PIN_EXT0 = 3;     // external interrupt 0 / gate 0
   localparam int unsigned PIN_EXT1 = 4;     // external interrupt 1 / gate 1
   localparam int unsigned PIN_LFCLK = 5;    // low_freq_clock

   // ----------------------------------------------------------------
   // timer mode register fields (per timer nibble)
   // ----------------------------------------------------------------
   localparam int unsigned MODE_T0_LSB = 0;
   localparam int unsigned CT_T0_BIT = 2;
   localparam int unsigned GATE_T0_BIT = 3;
   localparam int unsigned MODE_T1_LSB = 4;
   localparam int unsigned CT_T1_BIT = 6;
   localparam int unsigned GATE_T1_BIT = 7;

   typedef enum logic [1:0] {
      MODE_13BIT = 2'b00,
      MODE_16BIT = 2'b01,
      MODE_8RELOAD = 2'b10,
      MODE_SPLIT = 2'b11
   } timer_mode_t;

   // ----------------------------------------------------------------
   // third timer control fields
   // ----------------------------------------------------------------
   localparam int unsigned PRESCALE_SELECT_BIT = 7;
   localparam int unsigned RELOAD_ENABLE_BIT = 4;
   localparam int unsigned RELOAD_MODE_BIT = 3;
   localparam int unsigned INPUT_SELECT_LSB = 0;

   typedef enum logic [1:0] {
      T2_STOPPED = 2'b00,
      T2_TIMER = 2'b01,
      T2_EVENT = 2'b10,
      T2_GATED = 2'b11
   } input_select_t;

   // ----------------------------------------------------------------
   // software byte write selector
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      WR_T0_LOW = 3'h0,
      WR_T0_HIGH = 3'h1,
      WR_T1_LOW = 3'h2,
      WR_T1_HIGH = 3'h3,
      WR_T2_LOW = 3'h4,
      WR_T2_HIGH = 3'h5,
      WR_RELOAD_LOW = 3'h6,
      WR_RELOAD_HIGH = 3'h7
   } byte_sel_t;

   localparam int unsigned CAPTURE_COUNT = 4;
   localparam logic [7:0] BYTE_ALL_ONES = 8'hFF;
   localparam logic [15:0] WORD_ALL_ONES = 16'hFFFF;
   localparam logic [7:0] BYTE_RESET = 8'h00;
   localparam logic [15:0] WORD_RESET = 16'h0000;

endpackage : mcu_timer_pkg

// ---- include/pin_sync_if.sv ----
// synchronised pin levels and falling/rising events between sync and timers
`timescale 1ns/1ps
`default_nettype none
interface pin_sync_if #(parameter int unsigned WIDTH = 6);
   logic [WIDTH-1:0] level;   // filtered, agreed pin level
   logic [WIDTH-1:0] fall;    // one-cycle pulse on 1-to-0
   logic [WIDTH-1:0] rise;    // one-cycle pulse on 0-to-1
   modport src (output level, output fall, output rise);
   modport dst (input level, input fall, input rise);
endinterface : pin_sync_if
`default_nettype wire

// ---- hdl/pin_sync.sv ----
// three-stage synchroniser with agreement filter and edge pulses
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
   parameter int unsigned WIDTH = 6
) (
   input wire logic clk,
   input wire logic rst,
   input wire logic [WIDTH-1:0] pinIn,
   pin_sync_if.src sync
);

   // ----------------------------------------------------------------
   // per-pin state
   // ----------------------------------------------------------------
   logic [WIDTH-1:0] stage1_q;   // metastability catcher, read by stage2 only
   logic [WIDTH-1:0] stage2_q;
   logic [WIDTH-1:0] stage3_q;
   logic [WIDTH-1:0] level_q;    // accepted level
   logic [WIDTH-1:0] level_d;
   logic [WIDTH-1:0] fall_q;
   logic [WIDTH-1:0] fall_d;
   logic [WIDTH-1:0] rise_q;
   logic [WIDTH-1:0] rise_d;

   genvar i;
   generate
      for (i = 0; i < WIDTH; i++) begin : gBit
         // a change is taken only when stage 2 and 3 agree
         always_comb begin
            level_d[i] = (stage2_q[i] == stage3_q[i]) ? stage3_q[i] : level_q[i];
            fall_d[i] = level_q[i] & ~level_d[i];
            rise_d[i] = ~level_q[i] & level_d[i];
         end
         // pins idle high so no spurious fall leaves reset
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               stage1_q[i] <= 1'b1;
               stage2_q[i] <= 1'b1;
               stage3_q[i] <= 1'b1;
               level_q[i] <= 1'b1;
               fall_q[i] <= 1'b0;
               rise_q[i] <= 1'b0;
            end else begin
               stage1_q[i] <= pinIn[i];
               stage2_q[i] <= stage1_q[i];
               stage3_q[i] <= stage2_q[i];
               level_q[i] <= level_d[i];
               fall_q[i] <= fall_d[i];
               rise_q[i] <= rise_d[i];
            end
         end
      end
   endgenerate

   assign sync.level = level_q;
   assign sync.fall = fall_q;
   assign sync.rise = rise_q;

endmodule : pin_sync
`default_nettype wire

// ---- hdl/mcu_timer_counter_unit.sv ----
// three timer/counters: two classic four-mode timers and a reload/capture timer
`timescale 1ns/1ps
`default_nettype none
module mcu_timer_counter_unit
   import mcu_timer_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   // pins
   input wire logic firstCountInput,
   input wire logic secondCountInput,
   input wire logic thirdCountGateInput,
   input wire logic extIntPin0,
   input wire logic extIntPin1,
   input wire logic lowFreqClock,
   // control levels
   input wire logic [7:0] timerModeReg,
   input wire logic firstRunBit,
   input wire logic secondRunBit,
   input wire logic extIntType0,
   input wire logic extIntType1,
   input wire logic [7:0] thirdTimerControlReg,
   // service acknowledges, one-cycle pulses
   input wire logic serviceT0,
   input wire logic serviceT1,
   input wire logic serviceExt0,
   input wire logic serviceExt1,
   input wire logic serviceT2,
   // software byte write
   input wire logic byteWrite,
   input wire logic [2:0] byteSelect,
   input wire logic [7:0] byteData,
   // capture strobes
   input wire logic [CAPTURE_COUNT-1:0] captureStrobe,
   // state
   output logic [7:0] t0CountHigh,
   output logic [7:0] t0CountLow,
   output logic [7:0] t1CountHigh,
   output logic [7:0] t1CountLow,
   output logic [7:0] thirdTimerCountHigh,
   output logic [7:0] thirdTimerCountLow,
   output logic [15:0] reloadValue,
   output logic [CAPTURE_COUNT-1:0][15:0] captureValue,
   output logic t0Overflow,
   output logic t1Overflow,
   output logic extIntFlag0,
   output logic extIntFlag1,
   output logic t2Overflow
);

   // ----------------------------------------------------------------
   // pin synchronisation
   // ----------------------------------------------------------------
   pin_sync_if #(.WIDTH(PIN_COUNT)) pins ();

   pin_sync #(.WIDTH(PIN_COUNT)) uSync (
      .clk(clk),
      .rst(rst),
      .pinIn({lowFreqClock, extIntPin1, extIntPin0, thirdCountGateInput, secondCountInput, firstCountInput}),
      .sync(pins.src)
   );

   // ----------------------------------------------------------------
   // prescaler: base tick and half-rate tick
   // ----------------------------------------------------------------
   logic [3:0] presc_q;    // 0..BASE_DIV-1
   logic [3:0] presc_d;
   logic half_q;           // toggles each base tick
   logic half_d;
   logic lfDiv_q;          // low clock divided by two
   logic lfDiv_d;
   logic tickBase;
   logic tickT2;
   logic reloadTrigFall;

   // one shared divider keeps all clock-based timers in phase
   always_comb begin
      tickBase = (presc_q == BASE_DIV_LAST);
      presc_d = tickBase ? 4'h0 : presc_q + 4'h1;
      half_d = tickBase ? ~half_q : half_q;
      tickT2 = thirdTimerControlReg[PRESCALE_SELECT_BIT] ? (tickBase & half_q) : tickBase;
      lfDiv_d = pins.rise[PIN_LFCLK] ? ~lfDiv_q : lfDiv_q;
      reloadTrigFall = pins.rise[PIN_LFCLK] & lfDiv_q;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         presc_q <= 4'h0;
         half_q <= 1'b0;
         lfDiv_q <= 1'b0;
      end else begin
         presc_q <= presc_d;
         half_q <= half_d;
         lfDiv_q <= lfDiv_d;
      end
   end

   // ----------------------------------------------------------------
   // one step of a classic timer: {overflow, high, low}
   // ----------------------------------------------------------------
   function automatic logic [16:0] stepTimer(input timer_mode_t m, input logic [7:0] hi, input logic [7:0] lo);
      logic [13:0] sum13;
      logic [16:0] res;
      sum13 = {1'b0, hi, lo[4:0]} + 14'h0001;
      res = {1'b0, hi, lo};
      unique case (m)
         MODE_13BIT: res = {sum13[13], sum13[12:5], lo[7:5], sum13[4:0]};
         MODE_16BIT: res = {1'b0, hi, lo} + 17'h0_0001;
         MODE_8RELOAD: begin
            if (lo == BYTE_ALL_ONES) begin
               res = {1'b1, hi, hi};
            end else begin
               res = {1'b0, hi, lo + 8'h01};
            end
         end
         MODE_SPLIT: res = {1'b0, hi, lo};
      endcase
      return res;
   endfunction : stepTimer

   // ----------------------------------------------------------------
   // timers 0 and 1 with their flags
   // ----------------------------------------------------------------
   logic [7:0] t0Hi_q, t0Hi_d, t0Lo_q, t0Lo_d;
   logic [7:0] t1Hi_q, t1Hi_d, t1Lo_q, t1Lo_d;
   logic tf0_q, tf0_d, tf1_q, tf1_d;
   logic ie0_q, ie0_d, ie1_q, ie1_d;
   timer_mode_t mode0, mode1;
   logic inc0, inc1, incSplitHigh;
   logic set0, set1;
   logic [16:0] step0, step1;
   logic [8:0] splitLow, splitHigh;

   always_comb begin
      mode0 = timer_mode_t'(timerModeReg[MODE_T0_LSB +: 2]);
      mode1 = timer_mode_t'(timerModeReg[MODE_T1_LSB +: 2]);
      // run bit plus optional gate on the external pin level
      inc0 = firstRunBit & (~timerModeReg[GATE_T0_BIT] | pins.level[PIN_EXT0])
           & (timerModeReg[CT_T0_BIT] ? pins.fall[PIN_FIRST] : tickBase);
      inc1 = secondRunBit & (~timerModeReg[GATE_T1_BIT] | pins.level[PIN_EXT1])
           & (timerModeReg[CT_T1_BIT] ? pins.fall[PIN_SECOND] : tickBase);
      // in split mode the high half is a plain timer run by the second run bit
      incSplitHigh = secondRunBit & tickBase;
      step0 = stepTimer(mode0, t0Hi_q, t0Lo_q);
      step1 = stepTimer(mode1, t1Hi_q, t1Lo_q);
      splitLow = {1'b0, t0Lo_q} + 9'h001;
      splitHigh = {1'b0, t0Hi_q} + 9'h001;
      t0Hi_d = t0Hi_q;
      t0Lo_d = t0Lo_q;
      t1Hi_d = t1Hi_q;
      t1Lo_d = t1Lo_q;
      set0 = 1'b0;
      set1 = 1'b0;
      if (mode0 == MODE_SPLIT) begin
         if (inc0) begin
            t0Lo_d = splitLow[7:0];
            set0 = splitLow[8];
         end
         if (incSplitHigh) begin
            t0Hi_d = splitHigh[7:0];
            set1 = splitHigh[8];
         end
      end else if (inc0) begin
         {set0, t0Hi_d, t0Lo_d} = step0;
      end
      // timer 1 keeps counting, but its overflow flag is lent to timer 0
      if (inc1 && mode1 != MODE_SPLIT) begin
         {t1Hi_d, t1Lo_d} = step1[15:0];
         if (mode0 != MODE_SPLIT) begin
            set1 = step1[16];
         end
      end
      // software byte writes override a simultaneous count
      if (byteWrite) begin
         unique case (byte_sel_t'(byteSelect))
            WR_T0_LOW: t0Lo_d = byteData;
            WR_T0_HIGH: t0Hi_d = byteData;
            WR_T1_LOW: t1Lo_d = byteData;
            WR_T1_HIGH: t1Hi_d = byteData;
            default: begin
            end
         endcase
      end
      // sticky flags; a set in the clearing cycle wins
      tf0_d = (tf0_q & ~serviceT0) | set0;
      tf1_d = (tf1_q & ~serviceT1) | set1;
      ie0_d = (ie0_q & ~serviceExt0)
            | (extIntType0 ? pins.fall[PIN_EXT0] : ~pins.level[PIN_EXT0]);
      ie1_d = (ie1_q & ~serviceExt1)
            | (extIntType1 ? pins.fall[PIN_EXT1] : ~pins.level[PIN_EXT1]);
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         t0Hi_q <= BYTE_RESET;
         t0Lo_q <= BYTE_RESET;
         t1Hi_q <= BYTE_RESET;
         t1Lo_q <= BYTE_RESET;
         tf0_q <= 1'b0;
         tf1_q <= 1'b0;
         ie0_q <= 1'b0;
         ie1_q <= 1'b0;
      end else begin
         t0Hi_q <= t0Hi_d;
         t0Lo_q <= t0Lo_d;
         t1Hi_q <= t1Hi_d;
         t1Lo_q <= t1Lo_d;
         tf0_q <= tf0_d;
         tf1_q <= tf1_d;
         ie0_q <= ie0_d;
         ie1_q <= ie1_d;
      end
   end

   // ----------------------------------------------------------------
   // timer 2 count, reload register and overflow flag
   // ----------------------------------------------------------------
   logic [15:0] t2_q, t2_d;
   logic [15:0] crc_q, crc_d;   // reload value for the count
   logic tf2_q, tf2_d;
   input_select_t t2Sel;
   logic inc2, reloadEnable, reloadMode1, set2;

   always_comb begin
      t2Sel = input_select_t'(thirdTimerControlReg[INPUT_SELECT_LSB +: 2]);
      reloadEnable = thirdTimerControlReg[RELOAD_ENABLE_BIT];
      reloadMode1 = thirdTimerControlReg[RELOAD_MODE_BIT];
      unique case (t2Sel)
         T2_STOPPED: inc2 = 1'b0;
         T2_TIMER: inc2 = tickT2;
         T2_EVENT: inc2 = pins.fall[PIN_THIRD];
         T2_GATED: inc2 = tickT2 & pins.level[PIN_THIRD];
      endcase
      t2_d = t2_q;
      crc_d = crc_q;
      set2 = 1'b0;
      // trigger reload takes priority over a coincident increment
      if (reloadEnable && reloadMode1 && reloadTrigFall) begin
         t2_d = crc_q;
      end else if (inc2) begin
         if (t2_q == WORD_ALL_ONES) begin
            set2 = 1'b1;
            t2_d = (reloadEnable && !reloadMode1) ? crc_q : WORD_RESET;
         end else begin
            t2_d = t2_q + 16'h0001;
         end
      end
      if (byteWrite) begin
         unique case (byte_sel_t'(byteSelect))
            WR_T2_LOW: t2_d[7:0] = byteData;
            WR_T2_HIGH: t2_d[15:8] = byteData;
            WR_RELOAD_LOW: crc_d[7:0] = byteData;
            WR_RELOAD_HIGH: crc_d[15:8] = byteData;
            default: begin
            end
         endcase
      end
      tf2_d = (tf2_q & ~serviceT2) | set2;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         t2_q <= WORD_RESET;
         crc_q <= WORD_RESET;
         tf2_q <= 1'b0;
      end else begin
         t2_q <= t2_d;
         crc_q <= crc_d;
         tf2_q <= tf2_d;
      end
   end

   // ----------------------------------------------------------------
   // capture registers: snapshot without pausing the count
   // ----------------------------------------------------------------
   logic [CAPTURE_COUNT-1:0][15:0] cap_q;
   logic [CAPTURE_COUNT-1:0][15:0] cap_d;

   genvar c;
   generate
      for (c = 0; c < CAPTURE_COUNT; c++) begin : gCapture
         // takes the count as it stood before this edge
         always_comb begin
            cap_d[c] = captureStrobe[c] ? t2_q : cap_q[c];
         end
         always_ff @(posedge clk or posedge rst) begin
            if (rst) begin
               cap_q[c] <= WORD_RESET;
            end else begin
               cap_q[c] <= cap_d[c];
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // outputs, all straight from flops
   // ----------------------------------------------------------------
   assign t0CountHigh = t0Hi_q;
   assign t0CountLow = t0Lo_q;
   assign t1CountHigh = t1Hi_q;
   assign t1CountLow = t1Lo_q;
   assign thirdTimerCountHigh = t2_q[15:8];
   assign thirdTimerCountLow = t2_q[7:0];
   assign reloadValue = crc_q;
   assign captureValue = cap_q;
   assign t0Overflow = tf0_q;
   assign t1Overflow = tf1_q;
   assign extIntFlag0 = ie0_q;
   assign extIntFlag1 = ie1_q;
   assign t2Overflow = tf2_q;

endmodule : mcu_timer_counter_unit
`default_nettype wire

// ---- tb/mcu_timer_counter_unit_assertions.sv ----
// port-level checks on the timer/counter unit
`timescale 1ns/1ps
`default_nettype none
module timer_unit_checker
   import mcu_timer_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [7:0] timerModeReg,
   input wire logic firstRunBit,
   input wire logic [7:0] thirdTimerControlReg,
   input wire logic thirdCountGateInput,
   input wire logic serviceT0,
   input wire logic byteWrite,
   input wire logic [7:0] t0CountHigh,
   input wire logic [7:0] t0CountLow,
   input wire logic [7:0] t1CountHigh,
   input wire logic [7:0] t1CountLow,
   input wire logic [7:0] thirdTimerCountHigh,
   input wire logic [7:0] thirdTimerCountLow,
   input wire logic t0Overflow
);
   // ------
   // shorthands
   // ------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   wire [1:0] mode0 = timerModeReg[1:0]; // timer 0 mode field
   wire [1:0] sel2 = thirdTimerControlReg[1:0]; // timer 2 source
   wire [15:0] t0Cnt = {t0CountHigh, t0CountLow};
   wire [15:0] t2Cnt = {thirdTimerCountHigh, thirdTimerCountLow};
   // writes excluded: software may load any value
   wire t0Clk = mode0 == MODE_16BIT && !timerModeReg[2] && !byteWrite;
   wire t2Quiet = !thirdTimerControlReg[4] && !byteWrite;
   // ------
   // properties
   // ------
   sequence s_tick0; $changed(t0CountLow) && $past(t0Clk); endsequence
   property p_rate0;
      s_tick0 |=> ($stable(t0CountLow) || !$past(t0Clk))[*8];
   endproperty
   a_rate0: assert property (p_rate0) else $error("t0 ticks too close");
   property p_step0;
      $changed(t0Cnt) && !$past(byteWrite) && $past(mode0) == MODE_16BIT |-> t0Cnt == $past(t0Cnt) + 16'h0001;
   endproperty
   a_step0: assert property (p_step0) else $error("t0 step not one");
   property p_top0; mode0 == MODE_13BIT && !byteWrite |=> $stable(t0CountLow[7:5]); endproperty
   a_top0: assert property (p_top0) else $error("t0 low top bits moved");
   property p_stop0; !firstRunBit && mode0 != MODE_SPLIT && !byteWrite |=> $stable(t0Cnt); endproperty
   a_stop0: assert property (p_stop0) else $error("t0 ran while stopped");
   property p_hold1;
      timerModeReg[5:4] == MODE_SPLIT && !byteWrite |=> $stable({t1CountHigh, t1CountLow});
   endproperty
   a_hold1: assert property (p_hold1) else $error("t1 moved in mode 3");
   sequence s_wrap16;
      mode0 == MODE_16BIT && t0Cnt == WORD_ALL_ONES && !byteWrite ##1 t0Cnt == WORD_RESET;
   endsequence
   property p_wrap16; s_wrap16 |-> t0Overflow; endproperty
   a_wrap16: assert property (p_wrap16) else $error("t0 wrap without flag");
   sequence s_wrap8;
      mode0 == MODE_8RELOAD && t0CountLow == BYTE_ALL_ONES && !byteWrite ##1 t0CountLow != BYTE_ALL_ONES;
   endsequence
   property p_reload8; s_wrap8 |-> t0CountLow == $past(t0CountHigh) && t0Overflow; endproperty
   a_reload8: assert property (p_reload8) else $error("t0 bad 8-bit reload");
   property p_clear0; $fell(t0Overflow) |-> $past(serviceT0); endproperty
   a_clear0: assert property (p_clear0) else $error("t0 flag fell unserviced");
   property p_stop2; sel2 == T2_STOPPED && t2Quiet |=> $stable(t2Cnt); endproperty
   a_stop2: assert property (p_stop2) else $error("t2 ran while stopped");
   sequence s_gateLow;
      (sel2 == T2_GATED && t2Quiet && !thirdCountGateInput)[*6];
   endsequence
   property p_gate2; s_gateLow |=> $stable(t2Cnt); endproperty
   a_gate2: assert property (p_gate2) else $error("t2 ran with gate low");
endmodule : timer_unit_checker
`default_nettype wire

// ---- tb/count_source_model.sv ----
// far side: sources on the count pins and a free low-frequency clock
`timescale 1ns/1ps
`default_nettype none
module count_source_model (
   input wire logic clk,
   output logic firstCountInput,
   output logic secondCountInput,
   output logic thirdCountGateInput,
   output logic lowFreqClock
);
   // ------
   // pin drivers
   // ------
   // pins rest high, as if pulled up
   initial begin
      {firstCountInput, secondCountInput, thirdCountGateInput} = 3'h7;
      lowFreqClock = 1'h0;
   end
   // free-running, phase unrelated to the core clock
   always #230 lowFreqClock = ~lowFreqClock;
   // masked pins to v, level kept hold cycles
   task automatic drive(input logic [2:0] m, input logic v, input int hold);
      @(posedge clk);
      #1;
      if (m[0]) firstCountInput = v;
      if (m[1]) secondCountInput = v;
      if (m[2]) thirdCountGateInput = v;
      repeat (hold - 1) @(posedge clk);
   endtask : drive
   // n falling edges on the masked pins
   task automatic pulse(input logic [2:0] m, input int n, input int hold);
      repeat (n) begin
         drive(m, 1'h0, hold);
         drive(m, 1'h1, hold);
      end
   endtask : pulse
endmodule : count_source_model
`default_nettype wire

// ---- tb/tb_mcu_timer_counter_unit.sv ----
// self-checking bench for the timer/counter unit
`timescale 1ns/1ps
`default_nettype none
module tb_mcu_timer_counter_unit
   import mcu_timer_pkg::*;
;
   // ------
   // nets
   // ------
   logic clk, rst, firstCountInput, secondCountInput, thirdCountGateInput, lowFreqClock;
   logic [7:0] timerModeReg, thirdTimerControlReg, byteData;
   logic firstRunBit, secondRunBit, byteWrite, extPin; // ext pins idle high
   logic [2:0] byteSelect;
   logic [4:0] svc; // service pulses t0, t1, ext0, ext1, t2
   logic [3:0] captureStrobe;
   logic [7:0] t0CountHigh, t0CountLow, t1CountHigh, t1CountLow, thirdTimerCountHigh, thirdTimerCountLow;
   logic [15:0] reloadValue;
   logic [CAPTURE_COUNT-1:0][15:0] captureValue;
   logic t0Overflow, t1Overflow, t2Overflow;
   int errors = 0, nTests = 0;
   mcu_timer_counter_unit dut (.*, .extIntPin0(extPin), .extIntPin1(extPin), .extIntType0(1'h1),
      .extIntType1(1'h1), .serviceT0(svc[0]), .serviceT1(svc[1]), .serviceExt0(svc[2]),
      .serviceExt1(svc[3]), .serviceT2(svc[4]), .extIntFlag0(), .extIntFlag1());
   count_source_model src (.clk, .firstCountInput, .secondCountInput, .thirdCountGateInput, .lowFreqClock);
   always #10 clk = ~clk;
   // ------
   // helpers
   // ------
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : cyc
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      nTests++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %0t value %h exp %h", $time, got, exp);
      end
   endtask : cmp
   task automatic cmpFlag(input logic got, input logic exp);
      cmp(16'(got), 16'(exp));
   endtask : cmpFlag
   // low byte then high byte, strobe held
   task automatic wr16(input logic [2:0] s, input logic [15:0] v);
      byteWrite = 1'h1;
      byteSelect = s;
      byteData = v[7:0];
      cyc(1);
      byteSelect = s + 3'h1;
      byteData = v[15:8];
      cyc(1);
      byteWrite = 1'h0;
      cyc(1);
   endtask : wr16
   function automatic logic [15:0] cnt(input int w);
      return w == 0 ? {t0CountHigh, t0CountLow} : w == 1 ? {t1CountHigh, t1CountLow} : {thirdTimerCountHigh, thirdTimerCountLow};
   endfunction : cnt
   // edges until timer w moves; a hang ends the run
   task automatic waitChg(input int w, output int n);
      logic [15:0] v = cnt(w);
      n = 0;
      while (cnt(w) === v) begin
         cyc(1);
         n++;
         if (n > 200) begin
            errors++;
            test_done();
         end
      end
   endtask : waitChg
   task automatic pulseSvc;
      svc = 5'h1F;
      cyc(1);
      svc = 5'h00;
   endtask : pulseSvc
   // ------
   // scenarios
   // ------
   task automatic t_rates;
      int n;
      cmp(cnt(0) | cnt(1) | cnt(2) | reloadValue, 16'h0000);
      timerModeReg = 8'h11;
      firstRunBit = 1'h1;
      secondRunBit = 1'h1;
      thirdTimerControlReg = 8'h01;
      for (int w = 0; w < 3; w++) begin
         waitChg(w, n);
         waitChg(w, n);
         cmp(16'(n), 16'h000C);
      end
      thirdTimerControlReg = 8'h81;
      waitChg(2, n);
      waitChg(2, n);
      cmp(16'(n), 16'h0018);
   endtask : t_rates
   task automatic t_modes;
      int n;
      {firstRunBit, secondRunBit} = 2'h0;
      timerModeReg = 8'h10;
      wr16(WR_T0_LOW, 16'hFFBF);
      firstRunBit = 1'h1;
      waitChg(0, n);
      cmp(cnt(0), 16'h00A0);
      cmpFlag(t0Overflow, 1'h1);
      pulseSvc();
      cyc(1);
      cmpFlag(t0Overflow, 1'h0);
      firstRunBit = 1'h0;
      timerModeReg = 8'h22;
      wr16(WR_T0_LOW, 16'h80FF);
      wr16(WR_T1_LOW, 16'h80FF);
      firstRunBit = 1'h1;
      secondRunBit = 1'h1;
      waitChg(1, n);
      cmp(cnt(0), 16'h8080);
      cmp(cnt(1), 16'h8080);
      cmpFlag(t1Overflow, 1'h1);
   endtask : t_modes
   task automatic t_split;
      int n;
      {firstRunBit, secondRunBit} = 2'h0;
      pulseSvc();
      timerModeReg = 8'h13;
      wr16(WR_T0_LOW, 16'h1000);
      wr16(WR_T1_LOW, 16'hFFFF);
      secondRunBit = 1'h1;
      waitChg(0, n);
      cmp(cnt(0), 16'h1100);
      cmp(cnt(1), 16'h0000);
      cmpFlag(t1Overflow, 1'h0);
      timerModeReg = 8'h33;
      cyc(30);
      cmp(cnt(1), 16'h0000);
   endtask : t_split
   task automatic t_events;
      timerModeReg = 8'h55;
      firstRunBit = 1'h1;
      thirdTimerControlReg = 8'h02;
      wr16(WR_T0_LOW, 16'hFFFE);
      wr16(WR_T1_LOW, 16'h0000);
      wr16(WR_T2_LOW, 16'h0000);
      src.pulse(3'h7, 3, 2);
      cyc(8);
      cmp(cnt(0), 16'h0001);
      cmpFlag(t0Overflow, 1'h1);
      cmp(cnt(1), 16'h0003);
      cmp(cnt(2), 16'h0003);
      firstRunBit = 1'h0;
      src.pulse(3'h7, 2, 2);
      cyc(8);
      cmp(cnt(0), 16'h0001);
      cmp(cnt(1), 16'h0005);
      cmp(cnt(2), 16'h0005);
   endtask : t_events
   task automatic t_timer2;
      int n;
      thirdTimerControlReg = 8'h03;
      src.drive(3'h4, 1'h0, 5);
      wr16(WR_T2_LOW, 16'h0000);
      cyc(40);
      cmp(cnt(2), 16'h0000);
      src.drive(3'h4, 1'h1, 1);
      waitChg(2, n);
      cmp(cnt(2), 16'h0001);
      thirdTimerControlReg = 8'h00;
      wr16(WR_RELOAD_LOW, 16'h1234);
      wr16(WR_T2_LOW, 16'hFFFF);
      cmp(reloadValue, 16'h1234);
      thirdTimerControlReg = 8'h11;
      waitChg(2, n);
      cmp(cnt(2), 16'h1234);
      cmpFlag(t2Overflow, 1'h1);
      thirdTimerControlReg = 8'h00;
      wr16(WR_T2_LOW, 16'hFFFF);
      thirdTimerControlReg = 8'h09;
      waitChg(2, n);
      cmp(cnt(2), 16'h0000);
      thirdTimerControlReg = 8'h00;
      wr16(WR_T2_LOW, 16'h0005);
      thirdTimerControlReg = 8'h18;
      waitChg(2, n);
      cmp(cnt(2), 16'h1234);
      thirdTimerControlReg = 8'h00;
      for (int i = 0; i < CAPTURE_COUNT; i++) begin
         wr16(WR_T2_LOW, 16'h00C0 + 16'(i));
         captureStrobe = 4'h1 << i;
         cyc(1);
         captureStrobe = 4'h0;
         cyc(1);
         cmp(captureValue[i], 16'h00C0 + 16'(i));
      end
   endtask : t_timer2
   task automatic test_done;
      $display("errors %0d checks %0d", errors, nTests);
      if (errors == 0 && nTests > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : test_done
   // ------
   // main sequence
   // ------
   initial begin
      {clk, firstRunBit, secondRunBit, byteWrite} = 4'h0;
      {rst, extPin} = 2'h3;
      {timerModeReg, thirdTimerControlReg, byteData} = 24'h0000_00;
      {byteSelect, svc, captureStrobe} = 12'h000;
      cyc(2);
      rst = 1'h0;
      cyc(1);
      t_rates();
      t_modes();
      t_split();
      t_events();
      t_timer2();
      test_done();
   end
endmodule : tb_mcu_timer_counter_unit
bind mcu_timer_counter_unit timer_unit_checker chk (.*);
`default_nettype wire
